// ===== sim/pmd_chk.sv
// Assertion checker for the peripheral module disable controller
`timescale 1ns/1ns
`default_nettype none

module pmd_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic cpu_sfr_wr,
  input wire logic cpu_sfr_rd,
  input wire logic [4:0] cpu_sfr_periph,
  input wire logic [23:0] periph_sfr_wr,
  input wire logic [191:0] periph_sfr_rdata,
  input wire logic [7:0] cpu_sfr_rdata,
  input wire logic [23:0] periph_rst_hold,
  input wire logic [23:0] periph_out_raw,
  input wire logic [23:0] periph_out,
  input wire logic nvm_rd_req,
  input wire logic nvm_wr_req,
  input wire logic nvm_ctrl_wr_req,
  input wire logic nvm_rd_en,
  input wire logic nvm_wr_en,
  input wire logic nvm_ctrl_wr_en,
  input wire logic instr_clk_en,
  input wire logic full_rate_system_clock_en,
  input wire logic instr_clk_en_out
);
  logic [7:0] exp_rd;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Expected read byte, blanked while off
  always_ff @(posedge aclk) begin
    if (!aresetn || !cpu_sfr_rd || cpu_sfr_periph > 5'd23) begin
      exp_rd <= 8'h00;
    end else if (periph_rst_hold[cpu_sfr_periph]) begin
      exp_rd <= 8'h00;
    end else begin
      exp_rd <= periph_sfr_rdata[cpu_sfr_periph*8 +: 8];
    end
  end

  AST_RST_CLEAR: assert property ($rose(aresetn) |->
    periph_rst_hold == 24'h0 && !s_axi_bvalid && full_rate_system_clock_en)
    else $error("state not cleared by reset");
  AST_OUT_FORCED: assert property ($past(aresetn) |->
    periph_out == ($past(periph_out_raw) & ~$past(periph_rst_hold)))
    else $error("peripheral output not forced");
  AST_SFR_WR: assert property (periph_sfr_wr == (((cpu_sfr_wr &&
    cpu_sfr_periph < 5'd24) ? (24'h1 << cpu_sfr_periph) : 24'h0) & ~periph_rst_hold))
    else $error("register write not blocked");
  AST_SFR_RD: assert property (cpu_sfr_rdata == exp_rd)
    else $error("register read not blanked");
  AST_NVM_BLOCK: assert property ({nvm_rd_en, nvm_wr_en, nvm_ctrl_wr_en} ==
    ({nvm_rd_req, nvm_wr_req, nvm_ctrl_wr_req} & {3{!periph_rst_hold[0]}}))
    else $error("memory access not blocked");
  AST_CLK_NET: assert property (instr_clk_en_out == instr_clk_en &&
    full_rate_system_clock_en == !periph_rst_hold[3])
    else $error("clock enable wrong");
  AST_WR_EDGE: assert property ($past(aresetn) && $changed(periph_rst_hold) |->
    $rose(s_axi_bvalid))
    else $error("disable bits moved without a write");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready)
    else $error("write response did not end");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_BLANK: cover property (cpu_sfr_rd && periph_rst_hold[8]);
  COV_NVM: cover property (nvm_rd_req && periph_rst_hold[0]);
endmodule : pmd_chk

bind pmd_ctrl pmd_chk chk_u (.*);

`default_nettype wire

// ===== sim/pmd_ctrl_tb.sv
// Self-checking bench for the peripheral module disable controller
`timescale 1ns/1ns
`default_nettype none

module pmd_ctrl_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic cpu_sfr_wr, cpu_sfr_rd;
  logic [4:0] cpu_sfr_periph;
  logic [7:0] cpu_sfr_rdata, sd;
  logic [23:0] periph_sfr_wr, periph_rst_hold, periph_out_raw, periph_out, offs, w;
  logic [191:0] periph_sfr_rdata;
  logic nvm_rd_req, nvm_wr_req, nvm_ctrl_wr_req, nvm_rd_en, nvm_wr_en, nvm_ctrl_wr_en;
  logic instr_clk_en, full_rate_system_clock_en, instr_clk_en_out;
  logic timer_zero_off, refclk_out_off, pin_change_irq_off, clock_tuning_off;
  logic periph_clock_net_off, memory_scanner_off, checksum_unit_off, nonvolatile_access_off;
  logic pulse_gen1_off, capcomp2_off, capcomp1_off, timer_six_off;
  logic timer_four_off, timer_two_off, timer_three_off, timer_one_off;
  logic logic_cell3_off, logic_cell2_off, logic_cell1_off, waveform_gen_off;
  logic numeric_oscillator_off, pulse_gen4_off, pulse_gen3_off, pulse_gen2_off;
  logic [11:0] adr [3];
  int fails, check_count, cycles;

  assign offs = {logic_cell3_off, logic_cell2_off, logic_cell1_off, waveform_gen_off,
    numeric_oscillator_off, pulse_gen4_off, pulse_gen3_off, pulse_gen2_off,
    pulse_gen1_off, capcomp2_off, capcomp1_off, timer_six_off,
    timer_four_off, timer_two_off, timer_three_off, timer_one_off,
    timer_zero_off, refclk_out_off, pin_change_irq_off, clock_tuning_off,
    periph_clock_net_off, memory_scanner_off, checksum_unit_off, nonvolatile_access_off};

  pmd_ctrl dut_u (.*);

  always #25 aclk = ~aclk;

  task automatic close_out;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // Hang guard
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic sfr_rd(input logic [4:0] id, output logic [7:0] d);
    @(posedge aclk);
    cpu_sfr_rd <= 1'b1;
    cpu_sfr_periph <= id;
    @(posedge aclk);
    cpu_sfr_rd <= 1'b0;
    #1 d = cpu_sfr_rdata;
  endtask : sfr_rd

  task automatic sfr_wr(input logic [4:0] id, output logic [23:0] q);
    @(posedge aclk);
    cpu_sfr_wr <= 1'b1;
    cpu_sfr_periph <= id;
    #1 q = periph_sfr_wr;
    @(posedge aclk);
    cpu_sfr_wr <= 1'b0;
  endtask : sfr_wr

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, cpu_sfr_wr, cpu_sfr_rd, cpu_sfr_periph, periph_out_raw} = '0;
    {nvm_rd_req, nvm_wr_req, nvm_ctrl_wr_req, instr_clk_en} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fails, check_count, cycles} = '0;
    s_axi_wstrb = 4'hF;
    for (int i = 0; i < 24; i++) periph_sfr_rdata[i*8 +: 8] = 8'hA0 + 8'(i);
    adr[0] = pmd_pkg::ADDR_DISABLE0;
    adr[1] = pmd_pkg::ADDR_DISABLE1;
    adr[2] = pmd_pkg::ADDR_DISABLE2;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      axi_rd(adr[r], rd, rs);
      chk(rd, 32'h0);
    end
    chk(periph_rst_hold, 32'h0);
    $display("test reset done");
    // Walking one, upper data bits set and ignored
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 8; b++) begin
        axi_wr(adr[r], 32'hFFFF_FF00 | (32'h1 << b), rs);
        chk(rs, pmd_pkg::RESP_OKAY);
        settle();
        chk(offs, 32'h1 << (8*r + b));
        chk(periph_rst_hold, 32'h1 << (8*r + b));
        axi_rd(adr[r], rd, rs);
        chk(rd, 32'h1 << b);
      end
      axi_wr(adr[r], 32'h0, rs);
    end
    axi_wr(12'h43C, 32'hFF, rs);
    chk(rs, pmd_pkg::RESP_SLVERR);
    axi_rd(12'h43C, rd, rs);
    chk(rs, pmd_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    // Write with byte lane zero off leaves the register alone
    s_axi_wstrb <= 4'hE;
    axi_wr(adr[1], 32'hFF, rs);
    chk(rs, pmd_pkg::RESP_OKAY);
    axi_rd(adr[1], rd, rs);
    chk(rd, 32'h0);
    s_axi_wstrb <= 4'hF;
    $display("test map done");
    periph_out_raw <= 24'hFFFFFF;
    axi_wr(adr[1], 32'h05, rs);
    settle();
    chk(periph_out, 32'hFFFAFF);
    sfr_rd(5'd8, sd);
    chk(sd, 32'h00);
    sfr_rd(5'd9, sd);
    chk(sd, 32'hA9);
    sfr_wr(5'd10, w);
    chk(w, 32'h0);
    sfr_wr(5'd9, w);
    chk(w, 32'h200);
    axi_wr(adr[1], 32'h0, rs);
    settle();
    chk(periph_rst_hold, 32'h0);
    chk(periph_out, 32'hFFFFFF);
    sfr_rd(5'd8, sd);
    chk(sd, 32'hA8);
    $display("test gate done");
    {nvm_rd_req, nvm_wr_req, nvm_ctrl_wr_req, instr_clk_en} <= 4'hF;
    settle();
    chk({nvm_rd_en, nvm_wr_en, nvm_ctrl_wr_en, full_rate_system_clock_en}, 32'hF);
    axi_wr(adr[0], 32'h09, rs);
    settle();
    chk({nvm_rd_en, nvm_wr_en, nvm_ctrl_wr_en, full_rate_system_clock_en}, 32'h0);
    chk(instr_clk_en_out, 32'h1);
    $display("test memory done");
    axi_wr(adr[2], 32'hFF, rs);
    @(posedge aclk) aresetn <= 1'b0;
    @(posedge aclk) aresetn <= 1'b1;
    settle();
    chk({offs, full_rate_system_clock_en}, 32'h1);
    $display("test rerun done");
    close_out();
  end
endmodule : pmd_ctrl_tb

`default_nettype wire

// ===== src/pmd_ctrl.sv
// Peripheral module disable controller with AXI4-Lite register access
`timescale 1ns/1ns
`default_nettype none

module pmd_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral special function register access
  input wire logic cpu_sfr_wr,
  input wire logic cpu_sfr_rd,
  input wire logic [4:0] cpu_sfr_periph,
  output logic [23:0] periph_sfr_wr,
  input wire logic [191:0] periph_sfr_rdata,
  output logic [7:0] cpu_sfr_rdata,
  // Peripheral resets and outputs
  output logic [23:0] periph_rst_hold,
  input wire logic [23:0] periph_out_raw,
  output logic [23:0] periph_out,
  // Non-volatile memory access
  input wire logic nvm_rd_req,
  input wire logic nvm_wr_req,
  input wire logic nvm_ctrl_wr_req,
  output logic nvm_rd_en,
  output logic nvm_wr_en,
  output logic nvm_ctrl_wr_en,
  // Clock network enables
  input wire logic instr_clk_en,
  output logic full_rate_system_clock_en,
  output logic instr_clk_en_out,
  // Individual disable levels
  output logic timer_zero_off,
  output logic refclk_out_off,
  output logic pin_change_irq_off,
  output logic clock_tuning_off,
  output logic periph_clock_net_off,
  output logic memory_scanner_off,
  output logic checksum_unit_off,
  output logic nonvolatile_access_off,
  output logic pulse_gen1_off,
  output logic capcomp2_off,
  output logic capcomp1_off,
  output logic timer_six_off,
  output logic timer_four_off,
  output logic timer_two_off,
  output logic timer_three_off,
  output logic timer_one_off,
  output logic logic_cell3_off,
  output logic logic_cell2_off,
  output logic logic_cell1_off,
  output logic waveform_gen_off,
  output logic numeric_oscillator_off,
  output logic pulse_gen4_off,
  output logic pulse_gen3_off,
  output logic pulse_gen2_off
);

  // Disable registers: byte 0 is reg0, byte 1 reg1, byte 2 reg2
  logic [7:0] module_disable_reg0, module_disable_reg1, module_disable_reg2;
  logic [7:0] next_module_disable_reg0, next_module_disable_reg1, next_module_disable_reg2;
  logic [23:0] off_vec;
  // Write channel state
  pmd_pkg::pmd_wr_state_t wr_state, next_wr_state;
  logic aw_got, next_aw_got;
  logic w_got, next_w_got;
  logic [11:0] aw_addr_q, next_aw_addr_q;
  logic [31:0] w_data_q, next_w_data_q;
  logic w_strb0_q, next_w_strb0_q;
  logic [1:0] next_bresp;
  logic next_bvalid;
  // Read channel state
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;
  // SFR read return
  logic [7:0] next_cpu_sfr_rdata;
  logic [191:0] sfr_rdata_gated;
  // Combined write request
  logic aw_take, w_take, have_aw, have_w;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_strb0, wr_fire, wr_hit, rd_fire, rd_hit;
  logic [7:0] rd_byte;
  assign off_vec = {module_disable_reg2, module_disable_reg1, module_disable_reg0};

  // Write address and data channels are open only while idle and not yet captured; read address while no read data is held
  assign s_axi_awready = (wr_state == pmd_pkg::PMD_WR_IDLE) && !aw_got;
  assign s_axi_wready = (wr_state == pmd_pkg::PMD_WR_IDLE) && !w_got;
  assign s_axi_arready = !s_axi_rvalid;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign have_aw = aw_got || aw_take;
  assign have_w = w_got || w_take;
  assign wr_addr = aw_got ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_got ? w_data_q : s_axi_wdata;
  assign wr_strb0 = w_got ? w_strb0_q : s_axi_wstrb[0];
  assign wr_fire = (wr_state == pmd_pkg::PMD_WR_IDLE) && have_aw && have_w;

  // Register map decode, word aligned
  always_comb begin
    unique case (wr_addr[11:2])
      pmd_pkg::ADDR_DISABLE0[11:2]: wr_hit = 1'b1;
      pmd_pkg::ADDR_DISABLE1[11:2]: wr_hit = 1'b1;
      pmd_pkg::ADDR_DISABLE2[11:2]: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_comb begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    unique case (s_axi_araddr[11:2])
      pmd_pkg::ADDR_DISABLE0[11:2]: rd_byte = module_disable_reg0;
      pmd_pkg::ADDR_DISABLE1[11:2]: rd_byte = module_disable_reg1;
      pmd_pkg::ADDR_DISABLE2[11:2]: rd_byte = module_disable_reg2;
      default: rd_hit = 1'b0;
    endcase
  end

  // Disable register next values; one means off
  always_comb begin
    next_module_disable_reg0 = module_disable_reg0;
    next_module_disable_reg1 = module_disable_reg1;
    next_module_disable_reg2 = module_disable_reg2;
    if (wr_fire && wr_strb0) begin
      if (wr_addr[11:2] == pmd_pkg::ADDR_DISABLE0[11:2]) begin
        next_module_disable_reg0 = wr_data[7:0];
      end
      if (wr_addr[11:2] == pmd_pkg::ADDR_DISABLE1[11:2]) begin
        next_module_disable_reg1 = wr_data[7:0];
      end
      if (wr_addr[11:2] == pmd_pkg::ADDR_DISABLE2[11:2]) begin
        next_module_disable_reg2 = wr_data[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_disable_reg0 <= pmd_pkg::DISABLE_RST;
      module_disable_reg1 <= pmd_pkg::DISABLE_RST;
      module_disable_reg2 <= pmd_pkg::DISABLE_RST;
    end else begin
      module_disable_reg0 <= next_module_disable_reg0;
      module_disable_reg1 <= next_module_disable_reg1;
      module_disable_reg2 <= next_module_disable_reg2;
    end
  end

  // Write channel: capture address and data in either order
  always_comb begin
    next_wr_state = wr_state;
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_addr_q = aw_addr_q;
    next_w_data_q = w_data_q;
    next_w_strb0_q = w_strb0_q;
    next_bresp = s_axi_bresp;
    next_bvalid = s_axi_bvalid;
    unique case (wr_state)
      pmd_pkg::PMD_WR_IDLE: begin
        if (aw_take) begin
          next_aw_got = 1'b1;
          next_aw_addr_q = s_axi_awaddr;
        end
        if (w_take) begin
          next_w_got = 1'b1;
          next_w_data_q = s_axi_wdata;
          next_w_strb0_q = s_axi_wstrb[0];
        end
        if (wr_fire) begin
          next_wr_state = pmd_pkg::PMD_WR_RESP;
          next_bvalid = 1'b1;
          next_bresp = wr_hit ? pmd_pkg::RESP_OKAY : pmd_pkg::RESP_SLVERR;
        end
      end
      pmd_pkg::PMD_WR_RESP: begin
        if (s_axi_bready) begin
          next_wr_state = pmd_pkg::PMD_WR_IDLE;
          next_bvalid = 1'b0;
          next_aw_got = 1'b0;
          next_w_got = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= pmd_pkg::PMD_WR_IDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h00000000;
      w_strb0_q <= 1'b0;
      s_axi_bresp <= pmd_pkg::RESP_OKAY;
      s_axi_bvalid <= 1'b0;
    end else begin
      wr_state <= next_wr_state;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr_q <= next_aw_addr_q;
      w_data_q <= next_w_data_q;
      w_strb0_q <= next_w_strb0_q;
      s_axi_bresp <= next_bresp;
      s_axi_bvalid <= next_bvalid;
    end
  end

  // Read channel: one cycle to data, held until taken
  always_comb begin
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rvalid = s_axi_rvalid;
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rdata = {24'h000000, rd_byte};
      next_rresp = rd_hit ? pmd_pkg::RESP_OKAY : pmd_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= pmd_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_rvalid <= next_rvalid;
    end
  end

  // One gate per peripheral; bit index equals peripheral id
  generate
    for (genvar gi = 0; gi < pmd_pkg::NUM_PERIPH; gi++) begin : g_periph
      pmd_gate u_gate (
        .aclk(aclk),
        .aresetn(aresetn),
        .off(off_vec[gi]),
        .out_raw(periph_out_raw[gi]),
        .sfr_wr_req(cpu_sfr_wr && (cpu_sfr_periph == 5'(gi))),
        .sfr_rdata_raw(periph_sfr_rdata[gi*8 +: 8]),
        .rst_hold(periph_rst_hold[gi]),
        .out_forced(periph_out[gi]),
        .sfr_wr(periph_sfr_wr[gi]),
        .sfr_rdata(sfr_rdata_gated[gi*8 +: 8])
      );
    end
  endgenerate

  // Registered SFR read return; unknown ids read as blank
  always_comb begin
    next_cpu_sfr_rdata = pmd_pkg::SFR_BLANK;
    if (cpu_sfr_rd && (cpu_sfr_periph < 5'(pmd_pkg::NUM_PERIPH))) begin
      next_cpu_sfr_rdata = sfr_rdata_gated[cpu_sfr_periph*8 +: 8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_sfr_rdata <= pmd_pkg::SFR_BLANK;
    end else begin
      cpu_sfr_rdata <= next_cpu_sfr_rdata;
    end
  end

  // Memory access blocking, including control register writes
  assign nvm_rd_en = nvm_rd_req && !nonvolatile_access_off;
  assign nvm_wr_en = nvm_wr_req && !nonvolatile_access_off;
  assign nvm_ctrl_wr_en = nvm_ctrl_wr_req && !nonvolatile_access_off;
  // Only the full-rate network is gated; quarter rate passes
  assign full_rate_system_clock_en = !periph_clock_net_off;
  assign instr_clk_en_out = instr_clk_en;

  // Named disable levels
  assign timer_zero_off = module_disable_reg0[pmd_pkg::POS_TIMER_ZERO];
  assign refclk_out_off = module_disable_reg0[pmd_pkg::POS_REFCLK_OUT];
  assign pin_change_irq_off = module_disable_reg0[pmd_pkg::POS_PIN_CHANGE_IRQ];
  assign clock_tuning_off = module_disable_reg0[pmd_pkg::POS_CLOCK_TUNING];
  assign periph_clock_net_off = module_disable_reg0[pmd_pkg::POS_PERIPH_CLOCK_NET];
  assign memory_scanner_off = module_disable_reg0[pmd_pkg::POS_MEMORY_SCANNER];
  assign checksum_unit_off = module_disable_reg0[pmd_pkg::POS_CHECKSUM_UNIT];
  assign nonvolatile_access_off = module_disable_reg0[pmd_pkg::POS_NONVOLATILE_ACCESS];
  assign pulse_gen1_off = module_disable_reg1[pmd_pkg::POS_PULSE_GEN1];
  assign capcomp2_off = module_disable_reg1[pmd_pkg::POS_CAPCOMP2];
  assign capcomp1_off = module_disable_reg1[pmd_pkg::POS_CAPCOMP1];
  assign timer_six_off = module_disable_reg1[pmd_pkg::POS_TIMER_SIX];
  assign timer_four_off = module_disable_reg1[pmd_pkg::POS_TIMER_FOUR];
  assign timer_two_off = module_disable_reg1[pmd_pkg::POS_TIMER_TWO];
  assign timer_three_off = module_disable_reg1[pmd_pkg::POS_TIMER_THREE];
  assign timer_one_off = module_disable_reg1[pmd_pkg::POS_TIMER_ONE];
  assign logic_cell3_off = module_disable_reg2[pmd_pkg::POS_LOGIC_CELL3];
  assign logic_cell2_off = module_disable_reg2[pmd_pkg::POS_LOGIC_CELL2];
  assign logic_cell1_off = module_disable_reg2[pmd_pkg::POS_LOGIC_CELL1];
  assign waveform_gen_off = module_disable_reg2[pmd_pkg::POS_WAVEFORM_GEN];
  assign numeric_oscillator_off = module_disable_reg2[pmd_pkg::POS_NUMERIC_OSC];
  assign pulse_gen4_off = module_disable_reg2[pmd_pkg::POS_PULSE_GEN4];
  assign pulse_gen3_off = module_disable_reg2[pmd_pkg::POS_PULSE_GEN3];
  assign pulse_gen2_off = module_disable_reg2[pmd_pkg::POS_PULSE_GEN2];

endmodule : pmd_ctrl

`default_nettype wire

// ===== src/pmd_gate.sv
// Per-peripheral reset hold, register blanking and output forcing
`timescale 1ns/1ns
`default_nettype none

module pmd_gate (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic off,
  input wire logic out_raw,
  input wire logic sfr_wr_req,
  input wire logic [7:0] sfr_rdata_raw,
  output logic rst_hold,
  output logic out_forced,
  output logic sfr_wr,
  output logic [7:0] sfr_rdata
);

  logic next_out_forced;

  // Held in reset for as long as the disable bit stands
  assign rst_hold = off;
  // Register file looks unimplemented while off
  assign sfr_wr = sfr_wr_req & ~off;
  assign sfr_rdata = off ? pmd_pkg::SFR_BLANK : sfr_rdata_raw;

  always_comb begin
    next_out_forced = off ? 1'b0 : out_raw;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_forced <= 1'b0;
    end else begin
      out_forced <= next_out_forced;
    end
  end

endmodule : pmd_gate

`default_nettype wire

// ===== src/pmd_pkg.sv
// Constants and types shared by the peripheral module disable block
package pmd_pkg;

  // Register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int NUM_REGS = 3;
  localparam int NUM_PERIPH = NUM_REGS * REG_W;
  localparam int PERIPH_ID_W = 5;

  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_DISABLE0 = 12'h10C;
  localparam logic [ADDR_W-1:0] IDX_DISABLE1 = 12'h10D;
  localparam logic [ADDR_W-1:0] IDX_DISABLE2 = 12'h10E;
  localparam logic [ADDR_W-1:0] ADDR_DISABLE0 = {IDX_DISABLE0[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_DISABLE1 = {IDX_DISABLE1[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_DISABLE2 = {IDX_DISABLE2[ADDR_W-3:0], 2'b00};

  // Values after reset
  localparam logic [REG_W-1:0] DISABLE_RST = 8'h00;
  localparam logic [REG_W-1:0] SFR_BLANK = 8'h00;

  // Field positions in module_disable_reg0
  localparam int POS_TIMER_ZERO = 7;
  localparam int POS_REFCLK_OUT = 6;
  localparam int POS_PIN_CHANGE_IRQ = 5;
  localparam int POS_CLOCK_TUNING = 4;
  localparam int POS_PERIPH_CLOCK_NET = 3;
  localparam int POS_MEMORY_SCANNER = 2;
  localparam int POS_CHECKSUM_UNIT = 1;
  localparam int POS_NONVOLATILE_ACCESS = 0;
  // Field positions in module_disable_reg1
  localparam int POS_PULSE_GEN1 = 7;
  localparam int POS_CAPCOMP2 = 6;
  localparam int POS_CAPCOMP1 = 5;
  localparam int POS_TIMER_SIX = 4;
  localparam int POS_TIMER_FOUR = 3;
  localparam int POS_TIMER_TWO = 2;
  localparam int POS_TIMER_THREE = 1;
  localparam int POS_TIMER_ONE = 0;
  // Field positions in module_disable_reg2
  localparam int POS_LOGIC_CELL3 = 7;
  localparam int POS_LOGIC_CELL2 = 6;
  localparam int POS_LOGIC_CELL1 = 5;
  localparam int POS_WAVEFORM_GEN = 4;
  localparam int POS_NUMERIC_OSC = 3;
  localparam int POS_PULSE_GEN4 = 2;
  localparam int POS_PULSE_GEN3 = 1;
  localparam int POS_PULSE_GEN2 = 0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic {
    PMD_WR_IDLE = 1'b0,
    PMD_WR_RESP = 1'b1
  } pmd_wr_state_t;

endpackage : pmd_pkg
